// ### rtl/frame_crc_pkg.sv
// shared constants and types for the serial frame checker
package frame_crc_pkg;
	localparam int WORD_BITS = 16;
	localparam int CRC_BITS = 8;
	localparam int FRAME_BITS = 24;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam int STAT_ERR_BIT = 3;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 13;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] CNT_RESET = 5'h00;
	localparam logic [4:0] CNT_WORD = 5'h10;
	localparam logic [4:0] CNT_FRAME = 5'h18;

	typedef struct packed {
		logic [2:0] addr;
		logic [12:0] payload;
	} wr_word_t;

	typedef struct packed {
		logic [23:0] shift_r;
		logic [4:0] cnt_r;
		logic sclk_r;
		logic sync_n_r;
		logic err_flag_r;
		logic fault_oe_r;
		logic frame_ok_r;
		logic frame_bad_r;
	} rx_state_t;
endpackage

// ### rtl/word_fifo.sv
// parameterised valid/ready fifo for received words
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// fill side
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	// drain side
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic full;
	logic empty;
	assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty = (wp_r == rp_r);
	assign wr_ready_out = !full;
	assign rd_valid_out = !empty;
	assign rd_data_out = mem_r[rp_r[AW-1:0]];
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (wr_valid_in && !full) begin
				mem_r[wp_r[AW-1:0]] <= wr_data_in;
				wp_r <= wp_r + 1'b1;
			end
			if (rd_ready_in && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### rtl/serial_frame_crc8_checker.sv
// serial write port receiver with crc-8 frame checking
// Operation
// - sixteen-bit word sampled on falling clock
// - check sequence evaluated when sync rises
// - good frame writes payload to register
// - mismatch pulls alert low, sets D3
// - status read clears flag, releases alert
// - crc-8 polynomial x8+x2+x+1 recomputed
// - alert is open-drain active-low output
`timescale 1ns/1ps
`default_nettype none
module serial_frame_crc8_checker
	import frame_crc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// serial link, sampled synchronously
	input wire logic sclk_in,
	input wire logic sdata_in,
	input wire logic sync_n_in,
	// status read strobe
	input wire logic status_rd_in,
	// fault alert, open drain
	output logic fault_n_out,
	output logic fault_oe_out,
	output logic packet_check_err_flag_out,
	// committed register writes
	output wr_word_t wr_word_out,
	output logic wr_valid_out,
	input wire logic wr_ready_in,
	// frame result pulses
	output logic frame_ok_out,
	output logic frame_bad_out,
	output logic overflow_out
);
	rx_state_t st_r;
	rx_state_t st_nxt;
	logic push;
	logic fifo_ready;
	logic ovf_r;
	logic [15:0] fifo_dout;
	logic fifo_valid;

	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = WORD_BITS - 1; i >= 0; i--) begin
			if (c[7] ^ d[i])
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		return c;
	endfunction

	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_r = sclk_in;
		st_nxt.sync_n_r = sync_n_in;
		st_nxt.frame_ok_r = 1'b0;
		st_nxt.frame_bad_r = 1'b0;
		push = 1'b0;
		if (!sync_n_in && st_r.sclk_r && !sclk_in) begin
			st_nxt.shift_r = {st_r.shift_r[22:0], sdata_in};
			if (st_r.cnt_r != 5'h1f)
				st_nxt.cnt_r = st_r.cnt_r + 5'h01;
		end
		if (sync_n_in && !st_r.sync_n_r) begin
			st_nxt.cnt_r = CNT_RESET;
			if (st_r.cnt_r == CNT_FRAME) begin
				if (crc8(st_r.shift_r[23:8]) == st_r.shift_r[7:0]) begin
					push = 1'b1;
					st_nxt.frame_ok_r = 1'b1;
				end else begin
					st_nxt.frame_bad_r = 1'b1;
				end
			end else if (st_r.cnt_r == CNT_WORD) begin
				push = 1'b1;
				st_nxt.frame_ok_r = 1'b1;
			end
		end
		if (status_rd_in)
			st_nxt.err_flag_r = 1'b0;
		if (st_nxt.frame_bad_r)
			st_nxt.err_flag_r = 1'b1;
		st_nxt.fault_oe_r = st_nxt.err_flag_r;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			// idle levels of the link, so no false edge after reset
			st_r <= '{shift_r: 24'h000000, cnt_r: CNT_RESET, sclk_r: 1'b1,
				sync_n_r: 1'b1, default: 1'b0};
			ovf_r <= 1'b0;
			fault_n_out <= 1'b0;
			wr_valid_out <= 1'b0;
			wr_word_out <= '0;
		end else begin
			st_r <= st_nxt;
			ovf_r <= push && !fifo_ready;
			fault_n_out <= 1'b0;
			if (!wr_valid_out || wr_ready_in) begin
				wr_valid_out <= fifo_valid;
				wr_word_out <= wr_word_t'(fifo_dout);
			end
		end
	end

	word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_data_in(st_r.cnt_r == CNT_FRAME ? st_r.shift_r[23:8]
			: st_r.shift_r[15:0]),
		.wr_valid_in(push),
		.wr_ready_out(fifo_ready),
		.rd_data_out(fifo_dout),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(!wr_valid_out || wr_ready_in)
	);

	assign fault_oe_out = st_r.fault_oe_r;
	assign packet_check_err_flag_out = st_r.err_flag_r;
	assign frame_ok_out = st_r.frame_ok_r;
	assign frame_bad_out = st_r.frame_bad_r;
	assign overflow_out = ovf_r;
endmodule
`default_nettype wire

// ### tb/crc_props.sv
// port assertions for the frame checker
`timescale 1ns/1ps
`default_nettype none
module crc_props (
	input wire logic clk_in, rst_in, sync_n_in, status_rd_in,
	input wire logic fault_n_out, fault_oe_out, wr_valid_out,
	input wire logic packet_check_err_flag_out, frame_ok_out, frame_bad_out
);
	wire flag = packet_check_err_flag_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_done; frame_ok_out || frame_bad_out; endsequence
	sequence s_commit; ##[1:4] wr_valid_out; endsequence
	a_sync_first: assert property (s_done |-> sync_n_in && $past(sync_n_in))
		else $error("early result");
	a_good_write: assert property (frame_ok_out |-> s_commit)
		else $error("no write");
	a_bad_flag: assert property (frame_bad_out |-> flag && fault_oe_out)
		else $error("no flag");
	a_read_clear: assert property (status_rd_in |=> !flag || frame_bad_out)
		else $error("flag kept");
	a_flag_hold: assert property (flag && !status_rd_in |=> flag)
		else $error("flag lost");
	a_alert_low: assert property (fault_n_out == 1'b0)
		else $error("alert level");
	a_alert_flag: assert property (fault_oe_out == flag)
		else $error("alert state");
	a_bad_drop: assert property (frame_bad_out |=> !wr_valid_out [*4])
		else $error("bad write");
endmodule
bind serial_frame_crc8_checker crc_props props (.*);
`default_nettype wire

// ### tb/host_model.sv
// host serial master sending frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_in,
	output logic sclk_out, sdata_out, sync_n_out
);
	initial {sclk_out, sdata_out, sync_n_out} = 3'b101;
	task automatic send(input logic [23:0] v, input int n);
		@(posedge clk_in) sync_n_out <= 0;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk_in) sdata_out <= v[i];
			repeat (2) @(posedge clk_in);
			sclk_out <= 0;
			repeat (2) @(posedge clk_in);
			sclk_out <= 1;
		end
		@(posedge clk_in) sync_n_out <= 1;
		sdata_out <= ~sdata_out;
		repeat (3) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ### tb/serial_frame_crc8_checker_bench.sv
// self-checking bench for the frame checker
`timescale 1ns/1ps
`default_nettype none
`define chk(n, e, g) begin num_checks++; if ((e) !== (g)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module serial_frame_crc8_checker_bench;
	import frame_crc_pkg::*;
	logic clk_in = 0, rst_in = 1, status_rd_in = 0, wr_ready_in = 1;
	logic sclk_in, sdata_in, sync_n_in, fault_n_out, fault_oe_out;
	logic packet_check_err_flag_out, wr_valid_out;
	logic frame_ok_out, frame_bad_out, overflow_out;
	wr_word_t wr_word_out;
	int errors = 0, num_checks = 0, k, drops = 0, got = 0;
	int oks = 0, bads = 0;
	logic [15:0] last_word = 16'h0000;
	// data word beside the check-byte corruption
	logic [23:0] rows [3] = '{24'h2abc00, 24'h000100, 24'h8000ff};
	always #12.5 clk_in = ~clk_in;
	always @(negedge clk_in) begin
		drops += overflow_out;
		got += wr_valid_out & wr_ready_in;
		oks += frame_ok_out;
		bads += frame_bad_out;
		if (wr_valid_out & wr_ready_in)
			last_word = wr_word_out;
	end
	host_model host (.clk_in(clk_in), .sclk_out(sclk_in),
		.sdata_out(sdata_in), .sync_n_out(sync_n_in));
	serial_frame_crc8_checker uut (.*);
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c = CRC_INIT;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rst_in <= 0;
		@(negedge clk_in) `chk("reset", 1'b0, packet_check_err_flag_out)
		`chk("reset oe", 1'b0, fault_oe_out)
		`chk("reset valid", 1'b0, wr_valid_out)
		foreach (rows[r]) begin
			oks = 0;
			bads = 0;
			got = 0;
			host.send({rows[r][23:8], crc8(rows[r][23:8]) ^ rows[r][7:0]}, 24);
			repeat (4) @(negedge clk_in);
			`chk("ok", rows[r][7:0] == 0, oks == 1)
			`chk("bad", rows[r][7:0] != 0, bads == 1)
			`chk("flag", rows[r][7:0] != 0, packet_check_err_flag_out)
			`chk("alert", packet_check_err_flag_out, fault_oe_out)
			`chk("alert level", 1'b0, fault_n_out)
			`chk("write", rows[r][7:0] == 0, got == 1)
			if (rows[r][7:0] == 0) `chk("word", rows[r][23:8], last_word)
			@(posedge clk_in) status_rd_in <= 1;
			@(posedge clk_in) status_rd_in <= 0;
			@(negedge clk_in) `chk("clear", 1'b0, fault_oe_out)
			`chk("cleared", 1'b0, packet_check_err_flag_out)
			$display("row %0d done", r);
		end
		@(posedge clk_in) wr_ready_in <= 0;
		// output register plus 16 fifo words hold 17, the 18th is dropped
		for (int n = 0; n < 18; n++) host.send(24'(n), 16);
		`chk("overflow", 1, drops)
		got = 0;
		@(posedge clk_in) wr_ready_in <= 1;
		repeat (40) @(posedge clk_in);
		`chk("drained", 17, got)
		`chk("last", 16'h0010, last_word)
		$display("fifo test done");
		host.send({16'h0001, crc8(16'h0001) ^ 8'h01}, 24);
		@(negedge clk_in) `chk("pre-reset", 1'b1, packet_check_err_flag_out)
		@(posedge clk_in) rst_in <= 1;
		repeat (3) @(posedge clk_in);
		rst_in <= 0;
		@(negedge clk_in) `chk("reset flag", 1'b0, packet_check_err_flag_out)
		`chk("reset alert", 1'b0, fault_oe_out)
		$display("reset test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
